// *** dmac_datapath.sv ***
// mac, alu and shifter datapath with registered write-back
// Function
// RQ1: unsigned mac takes low parts as unsigned
// RQ2: accumulator input shifted by 0, 1 or 16
// RQ3: exactly six three-operand mac operations
// RQ4: signed mac adds or subtracts unshifted accumulator
// RQ5: shift1 mac adds product to accumulator>>1
// RQ6: shift16 mac adds product to accumulator>>16
// RQ7: signed times unsigned, added to accumulator
// RQ8: plain multiply writes extended product, no accumulation
// RQ9: aliased operand registers still give correct results
// RQ10: alu takes one or two words, one result
// RQ11: dyadic ops take register or immediate; compare register-only
// RQ12: add, subtract, immediate forms and compare
// RQ13: twelve single-operand arithmetic operations
// RQ14: and, or, xor in register and immediate form
// RQ15: single-operand bitwise inversion
// RQ16: immediates zero-extended from bit 16 upward
// RQ17: shifter delivers any shift in one cycle
// RQ18: arithmetic right, logical right, logical left shifts
// RQ19: shift amount from bits 5..0 only
// RQ20: only one unit runs per cycle
// RQ21: alu and shifter write any register
// RQ22: register split low, high, extension parts
// RQ23: binary point between bits 31 and 30
// RQ24: product sign-extended, signed product lsb zero
// RQ25: most negative squared gives plus one
// RQ26: unsigned product right aligned, zero extended
`timescale 1ns/1ns
module dmac_datapath #(
  parameter int unsigned NUM_REGS = 8
) (
  input  wire logic                 ref_clk,     // core clock
  input  wire logic                 rst,         // synchronous reset, active high
  input  wire logic                 issue,       // one operation this cycle
  input  wire dmac_pkg::dmac_op_t   op,          // operation code
  input  wire logic                 use_imm,     // second operand is the immediate
  input  wire logic [15:0]          imm,         // 16-bit immediate
  input  wire logic [39:0]          src_a,       // first source register value
  input  wire logic [39:0]          src_b,       // second source register value
  input  wire logic [39:0]          dst_val,     // current destination value
  input  wire logic [$clog2(NUM_REGS)-1:0] dst_sel, // destination register
  output logic [39:0]               result_q,    // write-back data
  output logic [$clog2(NUM_REGS)-1:0] wr_sel_q,  // write-back register
  output logic                      wr_en_q,     // write-back strobe
  output logic                      reject_q     // illegal operand form
);
  typedef logic [39:0] dmac_w_t;

  dmac_shift_if sh ();

  dmac_w_t     opnd_b;
  dmac_w_t     acc_in;
  dmac_w_t     product;
  dmac_w_t     alu_res;
  dmac_w_t     mac_res;
  dmac_w_t     result_d;
  logic        is_mac;
  logic        is_alu;
  logic        is_shift;
  logic        illegal;
  logic [15:0] a_high;
  logic [15:0] b_high;
  logic [15:0] a_low;
  logic [15:0] b_low;

  // RQ22 register parts
  assign a_high = src_a[dmac_pkg::HIGH_LSB +: dmac_pkg::PART_W];
  assign b_high = src_b[dmac_pkg::HIGH_LSB +: dmac_pkg::PART_W];
  assign a_low  = src_a[dmac_pkg::PART_W-1:0];
  assign b_low  = src_b[dmac_pkg::PART_W-1:0];

  // RQ16 immediate zero fill
  // RQ11 register or immediate
  assign opnd_b = use_imm ? dmac_pkg::zext_imm(imm) : src_b;

  // RQ20 unit decode, at most one hot by construction (none for nop)
  always_comb begin
    is_mac   = 1'b0;
    is_alu   = 1'b0;
    is_shift = 1'b0;
    unique case (op)
      dmac_pkg::OP_NOP: ;
      dmac_pkg::OP_PLAIN_MUL, dmac_pkg::OP_SMUL_ADD, dmac_pkg::OP_SMUL_SUB, dmac_pkg::OP_SUMUL_ADD,
      dmac_pkg::OP_UUMUL_ADD, dmac_pkg::OP_SH1_SIGNED_MULTIPLY_ADD, dmac_pkg::OP_SH16_SIGNED_MULTIPLY_ADD: is_mac = 1'b1;
      dmac_pkg::OP_SHR_ARITH, dmac_pkg::OP_SHR_LOGIC, dmac_pkg::OP_SHL_LOGIC: is_shift = 1'b1;
      default: is_alu = 1'b1;
    endcase
  end

  // RQ11 compare refuses an immediate
  assign illegal = issue && use_imm && (op == dmac_pkg::OP_LESS_THAN);

  // RQ2 accumulator input shifter
  always_comb begin
    unique case (op)
      // RQ5 arithmetic shift by one
      dmac_pkg::OP_SH1_SIGNED_MULTIPLY_ADD:  acc_in = 40'($signed(dst_val) >>> 1);
      // RQ6 shift by sixteen
      dmac_pkg::OP_SH16_SIGNED_MULTIPLY_ADD: acc_in = 40'($signed(dst_val) >>> dmac_pkg::PART_W);
      default:                acc_in = dst_val;
    endcase
  end

  // RQ9 operands arrive as values, so aliasing is harmless
  // RQ24 sign extension and lsb alignment inside the helpers
  always_comb begin
    unique case (op)
      // RQ7 signed times unsigned
      dmac_pkg::OP_SUMUL_ADD: product = dmac_pkg::su_mul(a_high, b_low);
      // RQ1 unsigned low parts
      // RQ26 right aligned unsigned product
      dmac_pkg::OP_UUMUL_ADD: product = dmac_pkg::uu_mul(a_low, b_low);
      // RQ23 signed q15 product lands on the q31 point
      default:                product = dmac_pkg::fx_mul(a_high, b_high);
    endcase
  end

  // RQ3 six accumulate forms plus plain multiply
  always_comb begin
    unique case (op)
      // RQ8 no accumulation
      dmac_pkg::OP_PLAIN_MUL: mac_res = product;
      // RQ4 subtract form
      dmac_pkg::OP_SMUL_SUB:  mac_res = acc_in - product;
      default:                mac_res = acc_in + product;
    endcase
  end

  // leading redundant sign bits, referred to the 32-bit view
  function automatic dmac_w_t exponent_of(input dmac_w_t v);
    logic [5:0] n;
    logic       run;
    n   = 6'h00;
    run = 1'b1;
    for (int i = 38; i >= 0; i--) begin
      if (run && (v[i] == v[39])) begin
        n = 6'(n + 6'h01);
      end else begin
        run = 1'b0;
      end
    end
    exponent_of = 40'($signed({1'b0, n}) - $signed(7'(dmac_pkg::NORM_BIAS)));
  endfunction

  // one non-restoring-free divide step on the 24-bit divisor aligned to the high part
  function automatic dmac_w_t div_step(input dmac_w_t num, input dmac_w_t den);
    dmac_w_t t;
    dmac_w_t d;
    t = {num[38:0], 1'b0};
    d = t - {den[23:0], dmac_pkg::LOW_ZERO};
    div_step = d[39] ? t : (d | dmac_pkg::ONE40);
  endfunction

  // RQ10 one or two 40-bit operands, one result
  always_comb begin
    alu_res = dmac_pkg::ZERO40;
    unique case (op)
      // RQ12 dyadic arithmetic
      dmac_pkg::OP_ADD:       alu_res = src_a + opnd_b;
      dmac_pkg::OP_SUB:       alu_res = src_a - opnd_b;
      dmac_pkg::OP_LESS_THAN: alu_res = ($signed(src_a) < $signed(src_b)) ? dmac_pkg::ONE40 : dmac_pkg::ZERO40;
      // RQ13 monadic arithmetic
      dmac_pkg::OP_CLEAR:     alu_res = dmac_pkg::ZERO40;
      dmac_pkg::OP_INC:       alu_res = src_a + dmac_pkg::ONE40;
      dmac_pkg::OP_DECR:      alu_res = src_a - dmac_pkg::ONE40;
      dmac_pkg::OP_ABSOLUTE:  alu_res = src_a[39] ? (dmac_pkg::ZERO40 - src_a) : src_a;
      dmac_pkg::OP_NEGATE:    alu_res = dmac_pkg::ZERO40 - src_a;
      dmac_pkg::OP_CLIP: begin
        if ($signed(src_a) > $signed(dmac_pkg::CLIP_MAX)) begin
          alu_res = dmac_pkg::CLIP_MAX;
        end else if ($signed(src_a) < $signed(dmac_pkg::CLIP_MIN)) begin
          alu_res = dmac_pkg::CLIP_MIN;
        end else begin
          alu_res = src_a;
        end
      end
      dmac_pkg::OP_ROUND:     alu_res = (src_a + dmac_pkg::ROUND_BIAS) & dmac_pkg::ROUND_MASK;
      dmac_pkg::OP_EXPONENT:  alu_res = exponent_of(src_a);
      dmac_pkg::OP_COPY:      alu_res = src_a;
      // accumulative forms fold the source into the destination
      dmac_pkg::OP_ACC_ADD:   alu_res = dst_val + src_a;
      dmac_pkg::OP_ACC_SUB:   alu_res = dst_val - src_a;
      dmac_pkg::OP_DIV_STEP:  alu_res = div_step(dst_val, src_a);
      // RQ14 logic, register or immediate
      dmac_pkg::OP_AND:       alu_res = src_a & opnd_b;
      dmac_pkg::OP_OR:        alu_res = src_a | opnd_b;
      dmac_pkg::OP_XOR:       alu_res = src_a ^ opnd_b;
      // RQ15 one's complement
      dmac_pkg::OP_NOT:       alu_res = ~src_a;
      default:                alu_res = dmac_pkg::ZERO40;
    endcase
  end

  // RQ19 only bits 5..0 give the amount
  assign sh.amount = opnd_b[dmac_pkg::AMT_W-1:0];
  assign sh.data   = src_a;
  always_comb begin
    unique case (op)
      dmac_pkg::OP_SHR_LOGIC: sh.kind = dmac_pkg::SH_LOGIC_RIGHT;
      dmac_pkg::OP_SHL_LOGIC: sh.kind = dmac_pkg::SH_LOGIC_LEFT;
      default:                sh.kind = dmac_pkg::SH_ARITH_RIGHT;
    endcase
  end

  dmac_shifter u_shifter (
    .sh (sh.unit)
  );

  // RQ20 single result mux, one unit per cycle
  always_comb begin
    if (is_mac) begin
      result_d = mac_res;
    end else if (is_shift) begin
      result_d = sh.result;
    end else begin
      result_d = alu_res;
    end
  end

  // RQ21 write to any chosen register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_q <= dmac_pkg::ZERO40;
      wr_sel_q <= '0;
    end else if (issue && !illegal) begin
      result_q <= result_d;
      wr_sel_q <= dst_sel;
    end
  end

  // a refused compare leaves the register file untouched
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_en_q  <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      wr_en_q  <= issue && !illegal && (op != dmac_pkg::OP_NOP);
      reject_q <= illegal;
    end
  end

  sequence s_issue_sq_min;
    issue && op == dmac_pkg::OP_PLAIN_MUL && a_high == 16'h8000 && b_high == 16'h8000;
  endsequence

  sequence s_issue_shift16;
    issue && op == dmac_pkg::OP_SH16_SIGNED_MULTIPLY_ADD;
  endsequence

  a_plus_one_square: assert property (@(posedge ref_clk) disable iff (rst) // RQ25
    s_issue_sq_min |=> wr_en_q && result_q == dmac_pkg::PLUS_ONE_FX)
    else $error("min times min is not plus one");

  a_signed_lsb_zero: assert property (@(posedge ref_clk) disable iff (rst) // RQ24
    issue && op == dmac_pkg::OP_PLAIN_MUL |=> result_q[0] == 1'b0 && result_q[39] == result_q[32])
    else $error("signed product misaligned");

  a_mac_sub_form: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
    issue && op == dmac_pkg::OP_SMUL_SUB
    |=> result_q == $past(dst_val) - dmac_pkg::fx_mul($past(src_a[31:16]), $past(src_b[31:16])))
    else $error("multiply subtract wrong");

  a_mac_shift16: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
    s_issue_shift16 and (src_a[31:16] == 16'h0000)
    |=> result_q == {{16{$past(dst_val[39])}}, $past(dst_val[39:16])})
    else $error("shift16 accumulate wrong");

  a_uu_zero_ext: assert property (@(posedge ref_clk) disable iff (rst) // RQ26
    issue && op == dmac_pkg::OP_UUMUL_ADD && dst_val == dmac_pkg::ZERO40
    |=> result_q == 40'($past(src_a[15:0]) * $past(src_b[15:0])))
    else $error("unsigned product misplaced");

  a_imm_zero_fill: assert property (@(posedge ref_clk) disable iff (rst) // RQ16
    issue && use_imm && op == dmac_pkg::OP_AND |=> result_q[39:16] == 24'h00_0000)
    else $error("immediate not zero filled");

  a_cmp_refuse_imm: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
    issue && use_imm && op == dmac_pkg::OP_LESS_THAN
    |=> reject_q && !wr_en_q ##1 reject_q == $past(illegal))
    else $error("compare accepted an immediate");

  a_shift_amt_low: assert property (@(posedge ref_clk) disable iff (rst) // RQ19
    issue && op == dmac_pkg::OP_SHR_LOGIC && opnd_b[5:0] == 6'h00 |=> result_q == $past(src_a))
    else $error("upper amount bits not ignored");

  a_write_target: assert property (@(posedge ref_clk) disable iff (rst) // RQ21
    issue && is_alu && !illegal |=> wr_en_q && wr_sel_q == $past(dst_sel))
    else $error("write-back target lost");

  a_one_unit_only: assert property (@(posedge ref_clk) disable iff (rst) // RQ20
    $onehot0({is_mac, is_alu, is_shift}))
    else $error("two units active together");

  a_refused_holds: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
    illegal |=> result_q == $past(result_q) && wr_sel_q == $past(wr_sel_q))
    else $error("refused compare changed the write-back");

  a_mac_write_back: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
    issue && is_mac |=> wr_en_q && wr_sel_q == $past(dst_sel))
    else $error("multiply result not written back");

  a_nop_no_write: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
    issue && op == dmac_pkg::OP_NOP |=> !wr_en_q && !reject_q)
    else $error("idle slot wrote a register");
endmodule // dmac_datapath

// *** dmac_pkg.sv ***
// constants, opcodes and arithmetic helpers for the dsp datapath
package dmac_pkg;
  localparam int unsigned DATA_W    = 40;
  localparam int unsigned PART_W    = 16;
  localparam int unsigned EXT_W     = 8;
  localparam int unsigned REG_AW    = 3;
  localparam int unsigned AMT_W     = 6;
  localparam int unsigned HIGH_LSB  = 16;
  localparam int unsigned SIGN_BIT  = 31;
  localparam int unsigned NORM_BIAS = 8;
  localparam logic [5:0]  MAX_SHIFT = 6'h27;
  localparam logic [39:0] ZERO40    = 40'h00_0000_0000;
  localparam logic [39:0] ONE40     = 40'h00_0000_0001;
  localparam logic [39:0] ROUND_BIAS = 40'h00_0000_8000;
  localparam logic [39:0] ROUND_MASK = 40'hFF_FFFF_0000;
  localparam logic [39:0] CLIP_MAX   = 40'h00_7FFF_FFFF;
  localparam logic [39:0] CLIP_MIN   = 40'hFF_8000_0000;
  localparam logic [39:0] PLUS_ONE_FX = 40'h00_8000_0000;
  localparam logic [23:0] IMM_FILL   = 24'h00_0000;
  localparam logic [15:0] LOW_ZERO   = 16'h0000;

  typedef logic [DATA_W-1:0] dmac_word_t;

  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_PLAIN_MUL  = 5'h01,
    OP_SMUL_ADD   = 5'h02,
    OP_SMUL_SUB   = 5'h03,
    OP_SUMUL_ADD  = 5'h04,
    OP_UUMUL_ADD  = 5'h05,
    OP_SH1_SIGNED_MULTIPLY_ADD   = 5'h06,
    OP_SH16_SIGNED_MULTIPLY_ADD  = 5'h07,
    OP_ADD        = 5'h08,
    OP_SUB        = 5'h09,
    OP_LESS_THAN  = 5'h0A,
    OP_CLEAR      = 5'h0B,
    OP_INC        = 5'h0C,
    OP_DECR       = 5'h0D,
    OP_ABSOLUTE   = 5'h0E,
    OP_NEGATE     = 5'h0F,
    OP_CLIP       = 5'h10,
    OP_ROUND      = 5'h11,
    OP_EXPONENT   = 5'h12,
    OP_COPY       = 5'h13,
    OP_ACC_ADD    = 5'h14,
    OP_ACC_SUB    = 5'h15,
    OP_DIV_STEP   = 5'h16,
    OP_AND        = 5'h17,
    OP_OR         = 5'h18,
    OP_XOR        = 5'h19,
    OP_NOT        = 5'h1A,
    OP_SHR_ARITH  = 5'h1B,
    OP_SHR_LOGIC  = 5'h1C,
    OP_SHL_LOGIC  = 5'h1D
  } dmac_op_t;

  typedef enum logic [1:0] {
    SH_ARITH_RIGHT = 2'b00,
    SH_LOGIC_RIGHT = 2'b01,
    SH_LOGIC_LEFT  = 2'b10
  } dmac_shift_t;

  // signed q15 x q15, aligned so the product lsb is zero, sign extended
  function automatic dmac_word_t fx_mul(input logic [15:0] x, input logic [15:0] y);
    logic signed [31:0] p;
    p = $signed(x) * $signed(y);
    fx_mul = {{(EXT_W-1){p[31]}}, p, 1'b0};
  endfunction

  // signed part times unsigned integer, right aligned
  function automatic dmac_word_t su_mul(input logic [15:0] x, input logic [15:0] y);
    logic signed [32:0] p;
    p = $signed(x) * $signed({1'b0, y});
    su_mul = {{(EXT_W-1){p[32]}}, p};
  endfunction

  // unsigned integer product, zero extended
  function automatic dmac_word_t uu_mul(input logic [15:0] x, input logic [15:0] y);
    logic [31:0] p;
    p = x * y;
    uu_mul = {{EXT_W{1'b0}}, p};
  endfunction

  function automatic dmac_word_t zext_imm(input logic [15:0] imm);
    zext_imm = {IMM_FILL, imm};
  endfunction
endpackage

// *** dmac_regfile_model.sv ***
// register file and operand fetch standing in for the core decoder
`timescale 1ns/1ns
module dmac_regfile_model (
  input  wire logic        ref_clk,  // core clock
  input  wire logic        rst,      // synchronous reset, active high
  input  wire logic        load_en,  // preload strobe
  input  wire logic [2:0]  load_sel, // preload register
  input  wire logic [39:0] load_val, // preload value
  input  wire logic [2:0]  sel_a,    // first source register
  input  wire logic [2:0]  sel_b,    // second source register
  input  wire logic [2:0]  dst_sel,  // destination register
  input  wire logic        wr_en,    // write-back strobe
  input  wire logic [2:0]  wr_sel,   // write-back register
  input  wire logic [39:0] wr_data,  // write-back data
  output logic [39:0]      src_a,    // first operand
  output logic [39:0]      src_b,    // second operand
  output logic [39:0]      dst_val   // accumulator operand
);
  logic [39:0] regs_q [8];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= 40'h00_0000_0000;
      end
    end else if (load_en) begin
      regs_q[load_sel] <= load_val;
    end else if (wr_en) begin
      regs_q[wr_sel] <= wr_data;
    end
  end

  // aliased selects read one register
  // bypass so a back-to-back op sees the result still in flight
  assign src_a   = (wr_en && wr_sel == sel_a) ? wr_data : regs_q[sel_a];
  assign src_b   = (wr_en && wr_sel == sel_b) ? wr_data : regs_q[sel_b];
  assign dst_val = (wr_en && wr_sel == dst_sel) ? wr_data : regs_q[dst_sel];
endmodule // dmac_regfile_model

// *** dmac_shift_if.sv ***
// carrier between the datapath and its barrel shifter
`timescale 1ns/1ns
interface dmac_shift_if;
  logic [39:0]         data;
  logic [5:0]          amount;
  dmac_pkg::dmac_shift_t kind;
  logic [39:0]         result;

  modport issuer (output data, output amount, output kind, input result);
  modport unit   (input data, input amount, input kind, output result);
endinterface

// *** dmac_shifter.sv ***
// single-cycle 40-bit barrel shifter
`timescale 1ns/1ns
module dmac_shifter (
  dmac_shift_if.unit sh   // operand, amount, kind and result
);
  logic [39:0] fill;

  assign fill = (sh.kind == dmac_pkg::SH_ARITH_RIGHT && sh.data[39]) ? ~dmac_pkg::ZERO40 : dmac_pkg::ZERO40;

  // RQ17 any amount, one cycle
  always_comb begin
    sh.result = dmac_pkg::ZERO40;
    // amounts above 39 push everything out; only the fill remains
    if (sh.amount > dmac_pkg::MAX_SHIFT) begin
      sh.result = (sh.kind == dmac_pkg::SH_LOGIC_LEFT) ? dmac_pkg::ZERO40 : fill;
    end else begin
      unique case (sh.kind)
        // RQ18 arithmetic right
        dmac_pkg::SH_ARITH_RIGHT: sh.result = 40'($signed(sh.data) >>> sh.amount);
        // RQ18 logical right
        dmac_pkg::SH_LOGIC_RIGHT: sh.result = sh.data >> sh.amount;
        // RQ18 logical left
        dmac_pkg::SH_LOGIC_LEFT:  sh.result = sh.data << sh.amount;
        default:                  sh.result = dmac_pkg::ZERO40;
      endcase
    end
  end
endmodule // dmac_shifter

// *** tb.sv ***
// self-checking bench for the mac, alu and shifter datapath
`timescale 1ns/1ns
module tb;
  logic               ref_clk  = 1'b0;
  logic               rst      = 1'b1;
  logic               issue    = 1'b0;
  dmac_pkg::dmac_op_t op       = dmac_pkg::OP_NOP;
  logic               use_imm  = 1'b0;
  logic [15:0]        imm      = 16'h0000;
  logic               load_en  = 1'b0;
  logic [2:0]         load_sel = 3'h0;
  logic [39:0]        load_val = 40'h00_0000_0000;
  logic [2:0]         sel_a    = 3'h0;
  logic [2:0]         sel_b    = 3'h0;
  logic [2:0]         dst_sel  = 3'h0;
  logic [39:0]        src_a;
  logic [39:0]        src_b;
  logic [39:0]        dst_val;
  logic [39:0]        result_q;
  logic [2:0]         wr_sel_q;
  logic               wr_en_q;
  logic               reject_q;
  logic [39:0]        keep;
  int                 n_mismatch = 0;
  int                 compares   = 0;

  always #2 ref_clk = ~ref_clk;

  dmac_datapath #(.NUM_REGS(8)) dut_u (.ref_clk(ref_clk), .rst(rst), .issue(issue), .op(op),
    .use_imm(use_imm), .imm(imm), .src_a(src_a), .src_b(src_b), .dst_val(dst_val), .dst_sel(dst_sel),
    .result_q(result_q), .wr_sel_q(wr_sel_q), .wr_en_q(wr_en_q), .reject_q(reject_q));

  dmac_regfile_model rf_u (.ref_clk(ref_clk), .rst(rst), .load_en(load_en), .load_sel(load_sel),
    .load_val(load_val), .sel_a(sel_a), .sel_b(sel_b), .dst_sel(dst_sel), .wr_en(wr_en_q),
    .wr_sel(wr_sel_q), .wr_data(result_q), .src_a(src_a), .src_b(src_b), .dst_val(dst_val));

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  // strobes stay up between back-to-back calls; the next task drops what it does not use
  task automatic load(input logic [2:0] s, input logic [39:0] v);
    issue    = 1'b0;
    load_en  = 1'b1;
    load_sel = s;
    load_val = v;
    step();
  endtask

  task automatic run_op(input dmac_pkg::dmac_op_t o, input logic ui, input logic [15:0] iv,
                        input logic [2:0] a, input logic [2:0] b, input logic [2:0] d, input logic [39:0] want);
    load_en = 1'b0;
    issue   = 1'b1;
    op      = o;
    use_imm = ui;
    imm     = iv;
    sel_a   = a;
    sel_b   = b;
    dst_sel = d;
    step();
    check({39'h0, wr_en_q}, 40'h1);
    check({37'h0, wr_sel_q}, {37'h0, d});
    check(result_q, want);
  endtask

  task automatic mac(input dmac_pkg::dmac_op_t o, input logic [39:0] want);
    load(3'h2, 40'h00_1000_0000);
    run_op(o, 1'b1, 16'h1234, 3'h1, 3'h1, 3'h2, want);
  endtask

  task automatic t_mac();
    load(3'h1, 40'h00_4000_FFFF);
    mac(dmac_pkg::OP_PLAIN_MUL, 40'h00_2000_0000);
    mac(dmac_pkg::OP_SMUL_ADD, 40'h00_3000_0000);
    mac(dmac_pkg::OP_SMUL_SUB, 40'hFF_F000_0000);
    mac(dmac_pkg::OP_SH1_SIGNED_MULTIPLY_ADD, 40'h00_2800_0000);
    mac(dmac_pkg::OP_SH16_SIGNED_MULTIPLY_ADD, 40'h00_2000_1000);
    mac(dmac_pkg::OP_SUMUL_ADD, 40'h00_4FFF_C000);
    mac(dmac_pkg::OP_UUMUL_ADD, 40'h01_0FFE_0001);
    load(3'h1, 40'h00_8000_0000);
    run_op(dmac_pkg::OP_PLAIN_MUL, 1'b0, 16'h0, 3'h1, 3'h1, 3'h3, 40'h00_8000_0000);
    load(3'h3, 40'h00_4000_0000);
    run_op(dmac_pkg::OP_SMUL_ADD, 1'b0, 16'h0, 3'h3, 3'h3, 3'h3, 40'h00_6000_0000);
    load(3'h3, 40'h80_1234_5678);
    run_op(dmac_pkg::OP_SH16_SIGNED_MULTIPLY_ADD, 1'b0, 16'h0, 3'h0, 3'h0, 3'h3, 40'hFF_FF80_1234);
    load(3'h1, 40'h00_0000_FFFF);
    load(3'h4, 40'h00_0000_0000);
    run_op(dmac_pkg::OP_UUMUL_ADD, 1'b0, 16'h0, 3'h1, 3'h1, 3'h4, 40'h00_FFFE_0001);
  endtask

  task automatic alu(input dmac_pkg::dmac_op_t o, input logic ui, input logic [2:0] d, input logic [39:0] want);
    run_op(o, ui, 16'hFFFF, 3'h1, 3'h2, d, want);
  endtask

  task automatic t_alu();
    load(3'h1, 40'hF0_0000_1234);
    load(3'h2, 40'h00_1234_5678);
    alu(dmac_pkg::OP_ADD, 1'b1, 3'h4, 40'hF0_0001_1233);
    alu(dmac_pkg::OP_ADD, 1'b0, 3'h5, 40'hF0_1234_68AC);
    alu(dmac_pkg::OP_SUB, 1'b0, 3'h6, 40'hEF_EDCB_BBBC);
    alu(dmac_pkg::OP_SUB, 1'b1, 3'h7, 40'hEF_FFFF_1235);
    alu(dmac_pkg::OP_LESS_THAN, 1'b0, 3'h0, 40'h00_0000_0001);
    run_op(dmac_pkg::OP_LESS_THAN, 1'b0, 16'h0, 3'h2, 3'h1, 3'h7, 40'h0);
    alu(dmac_pkg::OP_AND, 1'b0, 3'h4, 40'h00_0000_1230);
    alu(dmac_pkg::OP_OR, 1'b0, 3'h5, 40'hF0_1234_567C);
    alu(dmac_pkg::OP_XOR, 1'b0, 3'h6, 40'hF0_1234_444C);
    alu(dmac_pkg::OP_AND, 1'b1, 3'h7, 40'h00_0000_1234);
    alu(dmac_pkg::OP_OR, 1'b1, 3'h0, 40'hF0_0000_FFFF);
    alu(dmac_pkg::OP_XOR, 1'b1, 3'h4, 40'hF0_0000_EDCB);
    alu(dmac_pkg::OP_NOT, 1'b0, 3'h5, 40'h0F_FFFF_EDCB);
    alu(dmac_pkg::OP_CLEAR, 1'b0, 3'h6, 40'h0);
    alu(dmac_pkg::OP_INC, 1'b0, 3'h7, 40'hF0_0000_1235);
    alu(dmac_pkg::OP_DECR, 1'b0, 3'h0, 40'hF0_0000_1233);
    alu(dmac_pkg::OP_NEGATE, 1'b0, 3'h4, 40'h0F_FFFF_EDCC);
    alu(dmac_pkg::OP_ABSOLUTE, 1'b0, 3'h5, 40'h0F_FFFF_EDCC);
    alu(dmac_pkg::OP_COPY, 1'b0, 3'h6, 40'hF0_0000_1234);
    alu(dmac_pkg::OP_CLIP, 1'b0, 3'h7, 40'hFF_8000_0000);
    alu(dmac_pkg::OP_ROUND, 1'b0, 3'h0, 40'hF0_0000_0000);
    alu(dmac_pkg::OP_EXPONENT, 1'b0, 3'h4, 40'hFF_FFFF_FFFB);
    alu(dmac_pkg::OP_ACC_ADD, 1'b0, 3'h2, 40'hF0_1234_68AC);
    load(3'h2, 40'h00_1234_5678);
    alu(dmac_pkg::OP_ACC_SUB, 1'b0, 3'h2, 40'h10_1234_4444);
    load(3'h3, 40'h00_0003_0000);
    load(3'h4, 40'h00_0000_0002);
    run_op(dmac_pkg::OP_DIV_STEP, 1'b0, 16'h0, 3'h4, 3'h4, 3'h3, 40'h00_0004_0001);
    // second step leans on the model's bypass of the result still in flight
    run_op(dmac_pkg::OP_DIV_STEP, 1'b0, 16'h0, 3'h4, 3'h4, 3'h3, 40'h00_0006_0003);
    load(3'h3, 40'h00_0000_8000);
    run_op(dmac_pkg::OP_DIV_STEP, 1'b0, 16'h0, 3'h4, 3'h4, 3'h3, 40'h00_0001_0000);
  endtask

  task automatic t_shift();
    load(3'h1, 40'h80_1234_5678);
    load(3'h2, 40'h00_0000_0027);
    load(3'h3, 40'hFF_FFFF_FFE7);
    run_op(dmac_pkg::OP_SHR_ARITH, 1'b1, 16'hFFC4, 3'h1, 3'h0, 3'h5, 40'hF8_0123_4567);
    run_op(dmac_pkg::OP_SHR_LOGIC, 1'b0, 16'h0, 3'h1, 3'h2, 3'h6, 40'h00_0000_0001);
    run_op(dmac_pkg::OP_SHR_ARITH, 1'b0, 16'h0, 3'h1, 3'h3, 3'h7, 40'hFF_FFFF_FFFF);
    run_op(dmac_pkg::OP_SHL_LOGIC, 1'b1, 16'h0000, 3'h1, 3'h0, 3'h0, 40'h80_1234_5678);
    run_op(dmac_pkg::OP_SHL_LOGIC, 1'b1, 16'h0024, 3'h1, 3'h0, 3'h4, 40'h80_0000_0000);
    run_op(dmac_pkg::OP_SHR_LOGIC, 1'b1, 16'h0010, 3'h1, 3'h0, 3'h5, 40'h00_0080_1234);
    run_op(dmac_pkg::OP_SHR_LOGIC, 1'b1, 16'hFFC0, 3'h1, 3'h0, 3'h6, 40'h80_1234_5678);
    run_op(dmac_pkg::OP_SHR_ARITH, 1'b1, 16'h003F, 3'h1, 3'h0, 3'h7, 40'hFF_FFFF_FFFF);
    run_op(dmac_pkg::OP_SHR_LOGIC, 1'b1, 16'h0028, 3'h1, 3'h0, 3'h4, 40'h00_0000_0000);
  endtask

  task automatic t_reject();
    keep    = result_q;
    issue   = 1'b1;
    op      = dmac_pkg::OP_LESS_THAN;
    use_imm = 1'b1;
    step();
    op = dmac_pkg::OP_NOP;
    check({39'h0, reject_q}, 40'h1);
    check({39'h0, wr_en_q}, 40'h0);
    check(result_q, keep);
    step();
    check({39'h0, reject_q}, 40'h0);
    check({39'h0, wr_en_q}, 40'h0);
  endtask

  task automatic t_b2b();
    load(3'h1, 40'h00_4000_0000);
    load(3'h3, 40'h00_0000_0000);
    load_en = 1'b0;
    issue   = 1'b1;
    op      = dmac_pkg::OP_SMUL_ADD;
    use_imm = 1'b0;
    sel_a   = 3'h1;
    sel_b   = 3'h1;
    dst_sel = 3'h3;
    step();
    check(result_q, 40'h00_2000_0000);
    step();
    issue = 1'b0;
    check(result_q, 40'h00_4000_0000);
    step();
    check({39'h0, wr_en_q}, 40'h0);
  endtask

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check(result_q, 40'h0);
    check({38'h0, wr_en_q, reject_q}, 40'h0);
    t_mac();
    t_alu();
    t_shift();
    t_reject();
    t_b2b();
    wrap_up();
  end
endmodule // tb
